//--- stop_mode_defines.vh
// register map, field positions and reset values of the stop-mode and oscillator-stop block
`ifndef STOP_MODE_DEFINES_VH
`define STOP_MODE_DEFINES_VH
// register indices; the byte address is four times the index
`define ADDR_PROCESSOR_A 8'h04
`define ADDR_PROCESSOR_B 8'h05
`define ADDR_CLOCK_A 8'h06
`define ADDR_CLOCK_B 8'h07
`define ADDR_WRITE_PROTECT 8'h0a
`define ADDR_OSC_DETECT 8'h0c
`define ADDR_FAST_OSC_A 8'h08
`define ADDR_FAST_OSC_B 8'h09
`define ADDR_FAST_OSC_C 8'h0b
`define ADDR_VOLT_DETECT 8'h31
`define ADDR_VOLT_MON1 8'h32
`define ADDR_VOLT_MON2 8'h33
`define ADDR_STATUS 8'h3e
`define ADDR_WAKE 8'h3f
// clock mode register a fields
`define CLK_A_PERIPH_STOP_WAIT 2
`define CLK_A_MAIN_STOP 5
`define CLK_A_CPU_DIV8 6
// clock mode register b fields
`define CLK_B_ALL_STOP 0
`define CLK_B_OSC_PIN_FUNC 3
`define CLK_B_LOWSPEED_OFF 4
`define CLK_B_DRIVE_HIGH 5
// oscillator stop detect register fields
`define DET_ENABLE_LO 0
`define DET_ENABLE_HI 1
`define DET_ONCHIP_SEL 2
`define DET_MAIN_STOPPED 3
`define DET_ENABLE_ON 2'b11
// fast oscillator control a fields
`define FAST_A_SELECT 1
// write protect fields
`define PROT_CLOCK 0
`define PROT_PROC 1
`define PROT_VOLT 3
`define PROT_WRITE_MASK 8'h3f
// reset values
`define RST_CLOCK_A 8'h08
`define RST_CLOCK_B 8'h20
`define RST_OSC_DETECT 8'h04
`define RST_PLAIN 8'h00
// axi response codes
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

//--- stop_mode_osc_stop_detect.v
// stop-mode controller, oscillator stop detector and write protect register
`include "stop_mode_defines.vh"
`default_nettype none
module stop_mode_osc_stop_detect
(
   // clock and reset
   input wire clock_in,
   input wire reset_in,
   // axi4-lite write address
   input wire [7:0] s_axi_awaddr_in,
   input wire s_axi_awvalid_in,
   output reg s_axi_awready_out,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata_in,
   input wire [3:0] s_axi_wstrb_in,
   input wire s_axi_wvalid_in,
   output reg s_axi_wready_out,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp_out,
   output reg s_axi_bvalid_out,
   input wire s_axi_bready_in,
   // axi4-lite read address
   input wire [7:0] s_axi_araddr_in,
   input wire s_axi_arvalid_in,
   output reg s_axi_arready_out,
   // axi4-lite read data
   output reg [31:0] s_axi_rdata_out,
   output reg [1:0] s_axi_rresp_out,
   output reg s_axi_rvalid_out,
   input wire s_axi_rready_in,
   // cpu and wake events
   input wire wait_mode_in,
   input wire periph_wake_irq_in,
   input wire main_clock_is_cpu_in,
   input wire main_osc_alive_in,
   // clock control outputs
   output reg stop_mode_out,
   output reg cpu_clock_run_out,
   output reg periph_clock_run_out,
   output reg irq_sequence_start_out,
   output reg osc_stop_irq_out,
   // oscillator output pin
   output reg osc_output_pin_out,
   output reg osc_output_pin_oe_out
);

   // ==========================================================
   // registers
   reg [7:0] clock_mode_reg_a_r;
   reg [7:0] clock_mode_reg_b_r;
   reg [7:0] osc_stop_detect_reg_r;
   reg [7:0] write_protect_control_r;
   reg [7:0] proc_mode_reg_a_r;
   reg [7:0] proc_mode_reg_b_r;
   reg [7:0] fast_osc_ctrl_a_r;
   reg [7:0] fast_osc_ctrl_b_r;
   reg [7:0] fast_osc_ctrl_c_r;
   reg [7:0] voltage_detect_ctrl_r;
   reg [7:0] voltage_mon1_ctrl_r;
   reg [7:0] voltage_mon2_ctrl_r;
   reg wake_pending_r;
   reg [2:0] osc_sync_r;
   reg osc_alive_r;

   // ==========================================================
   // write channel state
   reg aw_held_r;
   reg w_held_r;
   reg [7:0] aw_addr_r;
   reg [31:0] w_data_r;
   reg w_strb_r;
   wire wr_fire = aw_held_r && w_held_r && !s_axi_bvalid_out;

   // ==========================================================
   // decode helpers
   function known_addr;
      input [7:0] a;
      begin
         case (a)
            `ADDR_PROCESSOR_A, `ADDR_PROCESSOR_B, `ADDR_CLOCK_A, `ADDR_CLOCK_B,
            `ADDR_WRITE_PROTECT, `ADDR_OSC_DETECT, `ADDR_FAST_OSC_A,
            `ADDR_FAST_OSC_B, `ADDR_FAST_OSC_C, `ADDR_VOLT_DETECT,
            `ADDR_VOLT_MON1, `ADDR_VOLT_MON2, `ADDR_STATUS, `ADDR_WAKE:
               known_addr = 1'b1;
            default:
               known_addr = 1'b0;
         endcase
      end
   endfunction

   function [7:0] reg_read;
      input [7:0] a;
      begin
         case (a)
            `ADDR_PROCESSOR_A: reg_read = proc_mode_reg_a_r;
            `ADDR_PROCESSOR_B: reg_read = proc_mode_reg_b_r;
            `ADDR_CLOCK_A: reg_read = clock_mode_reg_a_r;
            `ADDR_CLOCK_B: reg_read = clock_mode_reg_b_r;
            `ADDR_WRITE_PROTECT: reg_read = write_protect_control_r;
            `ADDR_OSC_DETECT: reg_read = osc_stop_detect_reg_r;
            `ADDR_FAST_OSC_A: reg_read = fast_osc_ctrl_a_r;
            `ADDR_FAST_OSC_B: reg_read = fast_osc_ctrl_b_r;
            `ADDR_FAST_OSC_C: reg_read = fast_osc_ctrl_c_r;
            `ADDR_VOLT_DETECT: reg_read = voltage_detect_ctrl_r;
            `ADDR_VOLT_MON1: reg_read = voltage_mon1_ctrl_r;
            `ADDR_VOLT_MON2: reg_read = voltage_mon2_ctrl_r;
            `ADDR_STATUS: reg_read = {4'h0, wait_mode_in, wake_pending_r,
               osc_alive_r, stop_mode_out};
            default: reg_read = 8'h00;
         endcase
      end
   endfunction

   // protected writes are accepted on the bus but change nothing
   wire wr_ok_clock = write_protect_control_r[`PROT_CLOCK];
   wire wr_ok_proc = write_protect_control_r[`PROT_PROC];
   wire wr_ok_volt = write_protect_control_r[`PROT_VOLT];
   wire [7:0] wd = w_data_r[7:0];
   wire wr_en = wr_fire && w_strb_r;
   wire hit_clock_b = wr_en && aw_addr_r == `ADDR_CLOCK_B && wr_ok_clock;
   wire enter_stop = hit_clock_b && wd[`CLK_B_ALL_STOP] && !stop_mode_out;
   wire detect_on = osc_stop_detect_reg_r[`DET_ENABLE_HI:`DET_ENABLE_LO] == `DET_ENABLE_ON;
   // second and third synchroniser stages agree on loss
   wire osc_lost = osc_alive_r && !osc_sync_r[1] && !osc_sync_r[2];
   wire detect_fire = detect_on && main_clock_is_cpu_in && osc_lost && !stop_mode_out
      && !osc_stop_detect_reg_r[`DET_ONCHIP_SEL];
   // pin level set on the stop entry edge itself, so inside stop it moves only on a write to clock mode register b
   wire pin_high = enter_stop ? wd[`CLK_B_OSC_PIN_FUNC]
      : stop_mode_out && clock_mode_reg_b_r[`CLK_B_OSC_PIN_FUNC];

   // ==========================================================
   // axi write channel
   always @(posedge clock_in)
   begin
      if (reset_in)
      begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 1'b0;
         s_axi_awready_out <= 1'b0;
         s_axi_wready_out <= 1'b0;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= `RESP_OKAY;
      end
      else
      begin
         s_axi_awready_out <= !aw_held_r && !s_axi_awready_out && s_axi_awvalid_in;
         s_axi_wready_out <= !w_held_r && !s_axi_wready_out && s_axi_wvalid_in;
         if (s_axi_awvalid_in && s_axi_awready_out)
         begin
            aw_held_r <= 1'b1;
            aw_addr_r <= {2'b00, s_axi_awaddr_in[7:2]};
         end
         if (s_axi_wvalid_in && s_axi_wready_out)
         begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata_in;
            w_strb_r <= s_axi_wstrb_in[0];
         end
         if (wr_fire)
         begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= known_addr(aw_addr_r) ? `RESP_OKAY : `RESP_SLVERR;
         end
         else if (s_axi_bvalid_out && s_axi_bready_in)
            s_axi_bvalid_out <= 1'b0;
      end
   end

   // ==========================================================
   // axi read channel
   always @(posedge clock_in)
   begin
      if (reset_in)
      begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= 32'h0000_0000;
         s_axi_rresp_out <= `RESP_OKAY;
      end
      else
      begin
         s_axi_arready_out <= !s_axi_arready_out && !s_axi_rvalid_out && s_axi_arvalid_in;
         if (s_axi_arvalid_in && s_axi_arready_out)
         begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out <= {24'h00_0000, reg_read({2'b00, s_axi_araddr_in[7:2]})};
            s_axi_rresp_out <= known_addr({2'b00, s_axi_araddr_in[7:2]}) ?
               `RESP_OKAY : `RESP_SLVERR;
         end
         else if (s_axi_rvalid_out && s_axi_rready_in)
            s_axi_rvalid_out <= 1'b0;
      end
   end

   // ==========================================================
   // register file, stop mode and detection
   always @(posedge clock_in)
   begin
      if (reset_in)
      begin
         clock_mode_reg_a_r <= `RST_CLOCK_A;
         clock_mode_reg_b_r <= `RST_CLOCK_B;
         osc_stop_detect_reg_r <= `RST_OSC_DETECT;
         write_protect_control_r <= `RST_PLAIN;
         proc_mode_reg_a_r <= `RST_PLAIN;
         proc_mode_reg_b_r <= `RST_PLAIN;
         fast_osc_ctrl_a_r <= `RST_PLAIN;
         fast_osc_ctrl_b_r <= `RST_PLAIN;
         fast_osc_ctrl_c_r <= `RST_PLAIN;
         voltage_detect_ctrl_r <= `RST_PLAIN;
         voltage_mon1_ctrl_r <= `RST_PLAIN;
         voltage_mon2_ctrl_r <= `RST_PLAIN;
         wake_pending_r <= 1'b0;
         osc_sync_r <= 3'b000;
         osc_alive_r <= 1'b0;
         stop_mode_out <= 1'b0;
         osc_stop_irq_out <= 1'b0;
         irq_sequence_start_out <= 1'b0;
      end
      else
      begin
         osc_sync_r <= {osc_sync_r[1:0], main_osc_alive_in};
         if (osc_sync_r[1] == osc_sync_r[2])
            osc_alive_r <= osc_sync_r[2];
         irq_sequence_start_out <= 1'b0;
         osc_stop_irq_out <= 1'b0;
         if (wr_en)
         begin
            case (aw_addr_r)
               `ADDR_WRITE_PROTECT:
                  write_protect_control_r <= wd & `PROT_WRITE_MASK;
               `ADDR_CLOCK_A:
                  if (wr_ok_clock) clock_mode_reg_a_r <= wd;
               `ADDR_CLOCK_B:
                  if (wr_ok_clock) clock_mode_reg_b_r <= wd;
               `ADDR_OSC_DETECT:
                  if (wr_ok_clock) osc_stop_detect_reg_r <= wd & 8'h07;
               `ADDR_FAST_OSC_A:
                  if (wr_ok_clock) fast_osc_ctrl_a_r <= wd;
               `ADDR_FAST_OSC_B:
                  if (wr_ok_clock) fast_osc_ctrl_b_r <= wd;
               `ADDR_FAST_OSC_C:
                  if (wr_ok_clock) fast_osc_ctrl_c_r <= wd;
               `ADDR_PROCESSOR_A:
                  if (wr_ok_proc) proc_mode_reg_a_r <= wd;
               `ADDR_PROCESSOR_B:
                  if (wr_ok_proc) proc_mode_reg_b_r <= wd;
               `ADDR_VOLT_DETECT:
                  if (wr_ok_volt) voltage_detect_ctrl_r <= wd;
               `ADDR_VOLT_MON1:
                  if (wr_ok_volt) voltage_mon1_ctrl_r <= wd;
               `ADDR_VOLT_MON2:
                  if (wr_ok_volt) voltage_mon2_ctrl_r <= wd;
               default:
                  ;
            endcase
         end
         // stop entry with forced divide-by-8 and high drive
         if (enter_stop)
         begin
            stop_mode_out <= 1'b1;
            clock_mode_reg_a_r[`CLK_A_CPU_DIV8] <= 1'b1;
            clock_mode_reg_b_r[`CLK_B_DRIVE_HIGH] <= 1'b1;
         end
         else if (stop_mode_out && periph_wake_irq_in)
         begin
            stop_mode_out <= 1'b0;
            clock_mode_reg_b_r[`CLK_B_ALL_STOP] <= 1'b0;
            wake_pending_r <= 1'b1;
         end
         // interrupt sequence once the cpu clock is back
         if (wake_pending_r && cpu_clock_run_out)
         begin
            wake_pending_r <= 1'b0;
            irq_sequence_start_out <= 1'b1;
         end
         // fallback to on-chip oscillator; stays until software reselects
         if (detect_fire)
         begin
            osc_stop_detect_reg_r[`DET_ONCHIP_SEL] <= 1'b1;
            osc_stop_detect_reg_r[`DET_MAIN_STOPPED] <= 1'b1;
            clock_mode_reg_b_r[`CLK_B_LOWSPEED_OFF] <= 1'b0;
            osc_stop_irq_out <= 1'b1;
         end
      end
   end

   // ==========================================================
   // clock gating and pin hold
   always @(posedge clock_in)
   begin
      if (reset_in)
      begin
         cpu_clock_run_out <= 1'b1;
         periph_clock_run_out <= 1'b1;
         osc_output_pin_out <= 1'b0;
         osc_output_pin_oe_out <= 1'b0;
      end
      else
      begin
         cpu_clock_run_out <= !stop_mode_out && !enter_stop && !wait_mode_in;
         periph_clock_run_out <= !stop_mode_out && !enter_stop
            && !(wait_mode_in && clock_mode_reg_a_r[`CLK_A_PERIPH_STOP_WAIT]);
         osc_output_pin_out <= pin_high;
         osc_output_pin_oe_out <= pin_high;
      end
   end

endmodule
`default_nettype wire

//--- main_osc_model.sv
// behavioural model of the external main oscillator and its activity monitor
`default_nettype none
module main_osc_model
#(
   parameter int HALF_NS = 60
)
(
   // control from the bench
   input wire logic run_in,
   // oscillator wave and activity level
   output logic osc_out,
   output logic alive_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================
   // oscillator
   initial osc_out = 1'b0;
   // wave stands still while stopped, above 2 MHz while running
   always #(HALF_NS) osc_out = run_in ? ~osc_out : 1'b0;
   // activity level lags the wave by a few half periods
   initial alive_out = 1'b1;
   always @(run_in) alive_out <= #(3 * HALF_NS) run_in;
endmodule
`default_nettype wire

//--- stop_mode_props.sv
// concurrent checks on the ports of the stop-mode and oscillator-stop block
`default_nettype none
module stop_mode_props
(
   // clock and reset
   input wire logic clock_in,
   input wire logic reset_in,
   // bus write response
   input wire logic [1:0] s_axi_bresp_out,
   input wire logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   // events
   input wire logic wait_mode_in,
   input wire logic periph_wake_irq_in,
   input wire logic main_osc_alive_in,
   // clock control and pin
   input wire logic stop_mode_out,
   input wire logic cpu_clock_run_out,
   input wire logic periph_clock_run_out,
   input wire logic irq_sequence_start_out,
   input wire logic osc_stop_irq_out,
   input wire logic osc_output_pin_out,
   input wire logic osc_output_pin_oe_out
);
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (reset_in);
   // ==========================================
   // wake steps
   sequence wake_s;
      stop_mode_out && periph_wake_irq_in ##1 !stop_mode_out;
   endsequence
   sequence resume_s;
      ##[0:1] cpu_clock_run_out ##[1:2] irq_sequence_start_out;
   endsequence
   // ==========================================
   // properties
   a_stop_halts_clocks: assert property (
      stop_mode_out |-> !cpu_clock_run_out && !periph_clock_run_out)
      else $error("clocks run in stop mode");
   a_wake_exits_stop: assert property (
      stop_mode_out && periph_wake_irq_in |=> !stop_mode_out)
      else $error("wake request did not end stop mode");
   a_stop_stays_put: assert property (
      stop_mode_out && !periph_wake_irq_in |=> stop_mode_out)
      else $error("stop mode left without a wake");
   a_wake_sequence: assert property (wake_s |-> resume_s)
      else $error("interrupt sequence missing after wake");
   a_irq_seq_cause: assert property (
      irq_sequence_start_out |-> $past(stop_mode_out, 2) || $past(stop_mode_out, 3))
      else $error("interrupt sequence without a stop wake");
   a_osc_irq_cause: assert property (
      osc_stop_irq_out |-> !stop_mode_out && (!$past(main_osc_alive_in, 2)
      || !$past(main_osc_alive_in, 3) || !$past(main_osc_alive_in, 4)
      || !$past(main_osc_alive_in, 5) || !$past(main_osc_alive_in, 6)))
      else $error("oscillator stop event without a stopped oscillator");
   a_pin_driven_high: assert property (
      stop_mode_out && osc_output_pin_oe_out |-> osc_output_pin_out)
      else $error("driven oscillator pin not high in stop mode");
   a_pin_held: assert property (
      stop_mode_out && $past(stop_mode_out) |->
      $stable(osc_output_pin_oe_out) && $stable(osc_output_pin_out))
      else $error("oscillator pin changed in stop mode");
   a_clocks_run: assert property (
      (!stop_mode_out && !wait_mode_in) [*3] |-> cpu_clock_run_out && periph_clock_run_out)
      else $error("clocks stopped outside stop and wait");
   a_bresp_held: assert property (
      s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
      else $error("write response dropped before it was taken");
endmodule
bind stop_mode_osc_stop_detect stop_mode_props stop_mode_props_inst (.*);
`default_nettype wire

//--- testbench.sv
// self-checking bench for the stop-mode and oscillator-stop block
`include "stop_mode_defines.vh"
`default_nettype none
`define CHK(nm, ex, got) begin exp_v = (ex); checked++; if ((got) !== exp_v) begin \
   miscompares++; $display("unexpected %s expected %h seen %h", nm, exp_v, got); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] PROT = `ADDR_WRITE_PROTECT << 2, CLKA = `ADDR_CLOCK_A << 2;
   localparam logic [7:0] CLKB = `ADDR_CLOCK_B << 2, DET = `ADDR_OSC_DETECT << 2;
   localparam logic [7:0] UNMAP = 8'h3c;
   localparam logic [1:0] OK = `RESP_OKAY;
   localparam logic [7:0] REGS [3] = '{CLKA, `ADDR_PROCESSOR_A << 2, `ADDR_VOLT_DETECT << 2};
   localparam logic [7:0] VALS [3] = '{8'h0c, 8'h01, 8'h01};
   localparam logic [7:0] RSTS [3] = '{`RST_CLOCK_A, `RST_PLAIN, `RST_PLAIN};
   localparam logic [7:0] BITS [3] = '{8'h01, 8'h02, 8'h08};
   logic clock_in = 0, reset_in = 1, osc_run = 1;
   logic [7:0] s_axi_awaddr_in = 0, s_axi_araddr_in = 0, r;
   logic [31:0] s_axi_wdata_in = 0;
   logic [3:0] s_axi_wstrb_in = 0, cnt;
   logic s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0;
   logic s_axi_arvalid_in = 0, s_axi_rready_in = 0;
   logic wait_mode_in = 0, periph_wake_irq_in = 0, main_clock_is_cpu_in = 1;
   wire logic main_osc_alive_in, s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
   wire logic s_axi_arready_out, s_axi_rvalid_out, stop_mode_out, cpu_clock_run_out;
   wire logic periph_clock_run_out, irq_sequence_start_out, osc_stop_irq_out;
   wire logic osc_output_pin_out, osc_output_pin_oe_out;
   wire logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
   wire logic [31:0] s_axi_rdata_out;
   int checked = 0, miscompares = 0, seed = 32'h08e3;
   logic [33:0] exp_v;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   stop_mode_osc_stop_detect stop_mode_osc_stop_detect_inst (.*);
   main_osc_model main_osc_model_inst (.run_in(osc_run), .osc_out(),
      .alive_out(main_osc_alive_in));
   initial forever #25 clock_in = ~clock_in;
   // ==========================================
   // result watcher
   always @(posedge clock_in)
   begin
      if (s_axi_bvalid_out && s_axi_bready_in)
         `CHK("write response", bq.pop_front(), s_axi_bresp_out)
      if (s_axi_rvalid_out && s_axi_rready_in)
         `CHK("read data", rq.pop_front(), {s_axi_rresp_out, s_axi_rdata_out})
   end
   // ==========================================
   // bus tasks
   task automatic wr(input logic [7:0] a, d, input logic [1:0] rs);
      logic [2:0] pend, h;
      bq.push_back(rs);
      @(posedge clock_in);
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= {24'h0, d};
      s_axi_wstrb_in <= 4'h1;
      pend = 3'b111;
      s_axi_awvalid_in <= 1;
      s_axi_wvalid_in <= 1;
      s_axi_bready_in <= 1;
      while (pend != 0)
      begin
         @(negedge clock_in);
         h = pend & {s_axi_bvalid_out, s_axi_wready_out, s_axi_awready_out};
         @(posedge clock_in);
         pend = pend & ~h;
         s_axi_awvalid_in <= pend[0];
         s_axi_wvalid_in <= pend[1];
         s_axi_bready_in <= pend[2];
      end
   endtask
   task automatic rd(input logic [7:0] a, d, input logic [1:0] rs);
      logic [1:0] pend, h;
      rq.push_back({rs, 24'h0, d});
      @(posedge clock_in);
      s_axi_araddr_in <= a;
      pend = 2'b11;
      s_axi_arvalid_in <= 1;
      s_axi_rready_in <= 1;
      while (pend != 0)
      begin
         @(negedge clock_in);
         h = pend & {s_axi_rvalid_out, s_axi_arready_out};
         @(posedge clock_in);
         pend = pend & ~h;
         s_axi_arvalid_in <= pend[0];
         s_axi_rready_in <= pend[1];
      end
   endtask
   task automatic results();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      #200_000;
      miscompares++;
      results();
   end
   // ==========================================
   // tests
   initial
   begin
      repeat (5) @(posedge clock_in);
      reset_in <= 0;
      rd(PROT, `RST_PLAIN, OK);
      rd(CLKA, `RST_CLOCK_A, OK);
      rd(CLKB, `RST_CLOCK_B, OK);
      rd(DET, `RST_OSC_DETECT, OK);
      wr(UNMAP, 8'hff, `RESP_SLVERR);
      rd(UNMAP, 8'h00, `RESP_SLVERR);
      r = 8'($random(seed));
      wr(PROT, r, OK);
      rd(PROT, r & 8'h3f, OK);
      $display("test reset values done");
      for (int k = 0; k < 3; k++)
      begin
         wr(PROT, 8'h00, OK);
         wr(REGS[k], VALS[k], OK);
         rd(REGS[k], RSTS[k], OK);
         wr(PROT, BITS[k], OK);
         wr(REGS[k], VALS[k], OK);
         rd(REGS[k], VALS[k], OK);
      end
      $display("test write protection done");
      wr(PROT, 8'h0b, OK);
      wr(CLKB, 8'h30, OK);
      for (int e = 0; e < 5; e++)
      begin
         wr(DET, (e > 3) ? 8'h03 : e[7:0], OK);
         main_clock_is_cpu_in <= (e != 3);
         osc_run <= 0;
         cnt = 0;
         repeat (20) @(negedge clock_in) cnt = cnt + osc_stop_irq_out;
         `CHK("stop event count", 4'(e == 4), cnt)
         osc_run <= 1;
         repeat (10) @(posedge clock_in);
      end
      rd(DET, 8'h0f, OK);
      rd(CLKB, 8'h20, OK);
      $display("test oscillator stop detection done");
      // software quiets detection first, then enters stop
      wr(DET, 8'h00, OK);
      wr(CLKB, 8'h09, OK);
      repeat (13) @(negedge clock_in);
      r = {3'b000, stop_mode_out, cpu_clock_run_out, periph_clock_run_out,
         osc_output_pin_oe_out, osc_output_pin_out};
      `CHK("stop outputs", 8'h13, r)
      @(posedge clock_in);
      periph_wake_irq_in <= 1;
      cnt = 0;
      repeat (6) @(negedge clock_in) cnt = cnt + irq_sequence_start_out;
      `CHK("wake pulses", 4'd1, cnt)
      `CHK("awake", 2'b01, {stop_mode_out, cpu_clock_run_out})
      @(posedge clock_in);
      periph_wake_irq_in <= 0;
      rd(CLKA, 8'h4c, OK);
      rd(CLKB, 8'h28, OK);
      for (int g = 0; g < 2; g++)
      begin
         wr(CLKA, g ? 8'h48 : 8'h4c, OK);
         wait_mode_in <= 1;
         repeat (4) @(negedge clock_in);
         `CHK("wait clocks", 2'(g), {cpu_clock_run_out, periph_clock_run_out})
         @(posedge clock_in);
         wait_mode_in <= 0;
      end
      wr(CLKB, 8'h01, OK);
      repeat (3) @(negedge clock_in);
      `CHK("port pin stop", 2'b10, {stop_mode_out, osc_output_pin_oe_out})
      @(posedge clock_in);
      reset_in <= 1;
      repeat (2) @(posedge clock_in);
      reset_in <= 0;
      repeat (2) @(negedge clock_in);
      `CHK("reset exit", 1'b0, stop_mode_out)
      rd(PROT, 8'h00, OK);
      $display("test stop mode done");
      results();
   end
endmodule
`default_nettype wire
